// File: verilog/thsup_consts.svh
// Constants for the connector thermal supervisor: offsets, fields, resets, timing
`ifndef THSUP_CONSTS_SVH
`define THSUP_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADR_CTRL      8'h00
`define ADR_STATUS    8'h04
`define ADR_IRQ_STAT  8'h08
`define ADR_IRQ_MASK  8'h0c
`define ADR_MAX_CUR   8'h10
`define ADR_NOCOOL    8'h14
`define ADR_FILTER    8'h18
`define ADR_TEMPS     8'h1c
`define ADR_PLAUS     8'h20

// ----------------------------------------------------------------------------
// Fields and event bits
// ----------------------------------------------------------------------------
`define CTRL_SERVICE  0
`define EV_W          5
`define EV_OVT        0
`define EV_SENS       1
`define EV_COOL       2
`define EV_PLAUS      3
`define EV_LOCK       4
`define OVT_LOCK_CNT  2'h3

// ----------------------------------------------------------------------------
// Reset values and limits (temperatures in 0.1 degC steps)
// ----------------------------------------------------------------------------
`define OVT_LIMIT     12'h384
`define RST_MAX_CUR   16'h01f4
`define RST_NOCOOL    16'h0000
`define RST_FILTER    24'h000000
`define RST_PMIN      12'h000
`define RST_PMAX      12'h7d0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SHDN_TIME_MS  9000
`define CLK_KHZ       25000
`define SHDN_CYCLES   (`SHDN_TIME_MS * `CLK_KHZ)

`endif

// File: verilog/thsup_pkg.sv
// Types shared by the connector thermal supervisor
package thsup_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHECK,
    ST_CHARGE,
    ST_SHUT
  } sup_state_t;

  // One sample of both contact sensors
  typedef struct packed {
    logic [11:0] pos;
    logic [11:0] neg;
    logic        pos_ok;
    logic        neg_ok;
  } temp_samp_t;

endpackage

// File: verilog/connector_thermal_supervisor.sv
// Thermal supervisor for the two d.c. contacts of the vehicle connector
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "thsup_consts.svh"

module connector_thermal_supervisor #(
  parameter int unsigned DEADLINE = `SHDN_CYCLES,
  parameter int          CNT_W    = 28
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  thsup_pkg::temp_samp_t      temp_i,
  input  wire logic                  cool_fail_i,
  input  wire logic                  session_req_i,
  input  wire logic                  session_end_i,
  output logic                       session_on_o,
  output logic                       shutdown_req_o,
  output logic      [15:0]           current_limit_o,
  output logic                       limit_update_o,
  output logic                       lockout_o,
  output logic                       irq_o
);

  localparam logic [CNT_W-1:0] DL_M1 = CNT_W'(DEADLINE - 1);

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic [31:0]       rdat_nxt;
  logic [31:0]       wm;
  logic [7:0]        word;
  logic              req;
  logic              wr;
  logic              sel_ctrl, sel_stat, sel_istat, sel_mask;
  logic              sel_maxc, sel_noc, sel_filt, sel_temps, sel_plaus;

  // Write commits on the edge where the master sees ack, as classic WB expects
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr    = req & wb_we_i & ack_r;
  assign word  = {wb_adr_i[7:2], 2'h0};
  assign sel_ctrl  = (word == `ADR_CTRL);
  assign sel_stat  = (word == `ADR_STATUS);
  assign sel_istat = (word == `ADR_IRQ_STAT);
  assign sel_mask  = (word == `ADR_IRQ_MASK);
  assign sel_maxc  = (word == `ADR_MAX_CUR);
  assign sel_noc   = (word == `ADR_NOCOOL);
  assign sel_filt  = (word == `ADR_FILTER);
  assign sel_temps = (word == `ADR_TEMPS);
  assign sel_plaus = (word == `ADR_PLAUS);

  // Byte lane masks
  for (genvar b = 0; b < 4; b++) begin : g_be
    assign wm[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  logic [`EV_W-1:0]  mask_r;
  logic [`EV_W-1:0]  stat_r;
  logic [`EV_W-1:0]  ev;
  logic [15:0]       maxc_r;
  logic [15:0]       noc_r;
  logic [23:0]       filt_r;
  logic [11:0]       pmin_r;
  logic [11:0]       pmax_r;
  logic              svc;
  logic [`EV_W-1:0]  w1c;

  assign svc = wr & sel_ctrl & wm[`CTRL_SERVICE] & wb_dat_i[`CTRL_SERVICE];
  assign w1c = (wr & sel_istat) ? (wb_dat_i[`EV_W-1:0] & wm[`EV_W-1:0]) : '0;

  // Byte-lane writes of the configuration registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mask_r <= '0;
      maxc_r <= `RST_MAX_CUR;
      noc_r  <= `RST_NOCOOL;
      filt_r <= `RST_FILTER;
      pmin_r <= `RST_PMIN;
      pmax_r <= `RST_PMAX;
    end else if (wr) begin
      if (sel_mask)  mask_r <= (mask_r & ~wm[`EV_W-1:0]) | (wb_dat_i[`EV_W-1:0] & wm[`EV_W-1:0]);
      if (sel_maxc)  maxc_r <= (maxc_r & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
      if (sel_noc)   noc_r  <= (noc_r & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
      if (sel_filt)  filt_r <= (filt_r & ~wm[23:0]) | (wb_dat_i[23:0] & wm[23:0]);
      if (sel_plaus) begin
        pmin_r <= (pmin_r & ~wm[11:0]) | (wb_dat_i[11:0] & wm[11:0]);
        pmax_r <= (pmax_r & ~wm[27:16]) | (wb_dat_i[27:16] & wm[27:16]);
      end
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) stat_r <= '0;
    else       stat_r <= (stat_r & ~w1c) | ev;
  end

  assign irq_o = |(stat_r & mask_r);

  // --------------------------------------------------------------------------
  // Per-contact evaluation
  // --------------------------------------------------------------------------
  logic [11:0] tv [2];
  logic [1:0]  okf;
  logic [1:0]  chan_ok;
  logic [1:0]  ovt;
  logic        ovt_any;
  logic        fault_any;

  assign tv[0] = temp_i.pos;
  assign tv[1] = temp_i.neg;
  assign okf   = {temp_i.neg_ok, temp_i.pos_ok};

  // Each contact has its own comparators; a hot pin is never averaged away.
  // A channel without signal carries no temperature, so it is a sensor fault
  // and never counts towards the overtemperature run.
  for (genvar k = 0; k < 2; k++) begin : g_chan
    assign chan_ok[k] = okf[k] & (tv[k] >= pmin_r) & (tv[k] <= pmax_r);
    assign ovt[k]     = okf[k] & (tv[k] > `OVT_LIMIT);
  end

  assign ovt_any   = |ovt;
  assign fault_any = ovt_any | ~(&chan_ok);

  // --------------------------------------------------------------------------
  // Session sequencer
  // --------------------------------------------------------------------------
  thsup_pkg::sup_state_t st_r, st_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [1:0]        ovtc_r, ovtc_nxt;
  logic              plk_r, plk_nxt;
  logic              shd_r, shd_nxt;
  logic              upd_r, upd_nxt;
  logic [15:0]       lim_r, lim_nxt;
  logic              locked;
  logic              fire;

  assign locked = (ovtc_r == `OVT_LOCK_CNT) | plk_r;
  // Filter longer than the deadline is cut short by the deadline compare
  assign fire   = fault_any &
                  ((cnt_r == CNT_W'(filt_r)) | (cnt_r == DL_M1));

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = '0;
    ovtc_nxt = ovtc_r;
    plk_nxt  = plk_r;
    shd_nxt  = shd_r;
    upd_nxt  = 1'b0;
    lim_nxt  = lim_r;
    ev       = '0;
    case (st_r)
      thsup_pkg::ST_IDLE: begin
        shd_nxt = 1'b0;
        if (session_req_i && !locked) st_nxt = thsup_pkg::ST_CHECK;
      end
      thsup_pkg::ST_CHECK: begin
        if (&chan_ok) begin
          st_nxt  = thsup_pkg::ST_CHARGE;
          lim_nxt = maxc_r;
        end else begin
          st_nxt            = thsup_pkg::ST_IDLE;
          plk_nxt           = 1'b1;
          lim_nxt           = noc_r;
          ev[`EV_PLAUS]     = 1'b1;
        end
      end
      thsup_pkg::ST_CHARGE: begin
        if (fault_any) cnt_nxt = cnt_r + 1'b1;
        if (fire) begin
          cnt_nxt = '0;
          st_nxt  = thsup_pkg::ST_SHUT;
          shd_nxt = 1'b1;
          if (ovt_any) begin
            ovtc_nxt      = ovtc_r + 2'h1;
            ev[`EV_OVT]   = 1'b1;
            ev[`EV_LOCK]  = (ovtc_r == `OVT_LOCK_CNT - 2'h1);
          end else begin
            ev[`EV_SENS]  = 1'b1;
          end
        end else if (cool_fail_i && noc_r == 16'h0000) begin
          st_nxt       = thsup_pkg::ST_SHUT;
          shd_nxt      = 1'b1;
          ev[`EV_COOL] = 1'b1;
        end else if (cool_fail_i && lim_r > noc_r) begin
          lim_nxt      = noc_r;
          upd_nxt      = 1'b1;
          ev[`EV_COOL] = 1'b1;
        end else if (session_end_i) begin
          st_nxt   = thsup_pkg::ST_IDLE;
          ovtc_nxt = 2'h0;
        end
      end
      thsup_pkg::ST_SHUT: begin
        if (session_end_i) st_nxt = thsup_pkg::ST_IDLE;
      end
      default: st_nxt = thsup_pkg::ST_IDLE;
    endcase
    // Service action lifts both lockouts
    if (svc) begin
      ovtc_nxt = 2'h0;
      plk_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r   <= thsup_pkg::ST_IDLE;
      cnt_r  <= '0;
      ovtc_r <= 2'h0;
      plk_r  <= 1'b0;
      shd_r  <= 1'b0;
      upd_r  <= 1'b0;
      lim_r  <= 16'h0000;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      ovtc_r <= ovtc_nxt;
      plk_r  <= plk_nxt;
      shd_r  <= shd_nxt;
      upd_r  <= upd_nxt;
      lim_r  <= lim_nxt;
    end
  end

  assign session_on_o    = (st_r == thsup_pkg::ST_CHARGE);
  assign shutdown_req_o  = shd_r;
  assign current_limit_o = lim_r;
  assign limit_update_o  = upd_r;
  assign lockout_o       = locked;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Unmapped offsets read zero and still acknowledge
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (sel_stat)
      rdat_nxt = {26'h0, plk_r, ovtc_r == `OVT_LOCK_CNT, ovtc_r, 2'(st_r)};
    else if (sel_istat) rdat_nxt = {27'h0, stat_r};
    else if (sel_mask)  rdat_nxt = {27'h0, mask_r};
    else if (sel_maxc)  rdat_nxt = {16'h0, maxc_r};
    else if (sel_noc)   rdat_nxt = {16'h0, noc_r};
    else if (sel_filt)  rdat_nxt = {8'h0, filt_r};
    else if (sel_temps)
      rdat_nxt = {3'h0, temp_i.neg_ok, temp_i.neg, 3'h0, temp_i.pos_ok, temp_i.pos};
    else if (sel_plaus) rdat_nxt = {4'h0, pmax_r, 4'h0, pmin_r};
  end

  // One wait state: ack follows the request by one edge, then drops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req & ~ack_r;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_ovt_deadline: assert property ((st_r == thsup_pkg::ST_CHARGE) && ovt_any
      && cnt_r == DL_M1 |=> shutdown_req_o && ovtc_r != $past(ovtc_r))
    else $error("overtemperature not shut down at deadline");
  a_cnt_bound: assert property (cnt_r <= DL_M1)
    else $error("fault counter ran past deadline");
  a_lock_three: assert property ((ovtc_r == `OVT_LOCK_CNT) && st_r == thsup_pkg::ST_IDLE
      |=> st_r == thsup_pkg::ST_IDLE)
    else $error("session started while overtemperature lockout");
  a_plaus_block: assert property ((st_r == thsup_pkg::ST_CHECK) && !(&chan_ok)
      |=> plk_r && lockout_o && st_r == thsup_pkg::ST_IDLE)
    else $error("failed check did not block start");
  a_plaus_limit: assert property ((st_r == thsup_pkg::ST_CHECK) && !(&chan_ok)
      |=> current_limit_o == $past(noc_r))
    else $error("failed check did not cap current");
  a_sens_deadline: assert property ((st_r == thsup_pkg::ST_CHARGE) && !(&chan_ok)
      && cnt_r == DL_M1 |=> shutdown_req_o && st_r == thsup_pkg::ST_SHUT)
    else $error("sensor fault not shut down at deadline");
  a_cool_stop: assert property ((st_r == thsup_pkg::ST_CHARGE) && cool_fail_i
      && noc_r == 16'h0000 |=> shutdown_req_o)
    else $error("cooling failure without fallback did not stop");
  a_limit_report: assert property ((st_r == thsup_pkg::ST_CHARGE)
      && $past(st_r) == thsup_pkg::ST_CHARGE && $changed(current_limit_o) |-> limit_update_o)
    else $error("limit change not reported to vehicle");
  a_count_clear: assert property ((st_r == thsup_pkg::ST_CHARGE) && !fire && !cool_fail_i
      && session_end_i |=> ovtc_r == 2'h0)
    else $error("run count not cleared on clean end");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_ovt_shut: cover property (st_r == thsup_pkg::ST_CHARGE ##1 st_r == thsup_pkg::ST_SHUT
      && ovtc_r != 2'h0);
  c_lockout: cover property (ovtc_r == `OVT_LOCK_CNT);
  c_cool_cut: cover property (limit_update_o);
  c_plaus_fail: cover property (plk_r && st_r == thsup_pkg::ST_IDLE);

endmodule // connector_thermal_supervisor

// File: testbench/thsup_partner.sv
// Model of the connector sensors and cooling plant facing the thermal supervisor
`timescale 1ns/1ps

module thsup_partner (
  input  wire logic             mclk_i,
  input  wire logic [11:0]      pos_set_i,
  input  wire logic [11:0]      neg_set_i,
  input  wire logic             pos_open_i,
  input  wire logic             neg_open_i,
  input  wire logic             cool_bad_i,
  output thsup_pkg::temp_samp_t temp_o,
  output logic                  cool_fail_o
);
  logic [11:0] noise_r = 12'h155;

  // --------------------------------------------------------------------------
  // Sensor channels
  // --------------------------------------------------------------------------
  // An open channel carries no value, so the reading wanders every cycle
  // instead of holding the last good temperature
  always_ff @(posedge mclk_i) begin
    noise_r     <= noise_r + 12'h3a7;
    temp_o.pos  <= pos_open_i ? noise_r : pos_set_i;
    temp_o.neg  <= neg_open_i ? ~noise_r : neg_set_i;
    temp_o.pos_ok <= !pos_open_i;
    temp_o.neg_ok <= !neg_open_i;
    cool_fail_o <= cool_bad_i;
  end
endmodule // thsup_partner

// File: testbench/connector_thermal_supervisor_bench.sv
// Self-checking bench for the connector thermal supervisor
`timescale 1ns/1ps

module connector_thermal_supervisor_bench;
  localparam int DL = 20;
  typedef struct { logic [7:0] adr; logic [31:0] exp; } row_t;
  logic                  mclk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, req = 1'b0, fin = 1'b0;
  logic                  pos_open = 1'b0, neg_open = 1'b0, cool_bad = 1'b0, cool_fail;
  logic                  on, shut, upd, lock, irq;
  logic [7:0]            adr = 8'h00;
  logic [3:0]            sel = 4'h0;
  logic [31:0]           dat = 32'h0, rd, wb_dat;
  logic [11:0]           pos_t = 12'h0fa, neg_t = 12'h104;
  logic [15:0]           lim;
  thsup_pkg::temp_samp_t temp;
  int                    failures = 0, cmp_count = 0, n;
  row_t rows [9] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0}, '{8'h0c, 32'h0},
    '{8'h10, 32'h1f4}, '{8'h14, 32'h0}, '{8'h18, 32'h0}, '{8'h1c, 32'h110410fa},
    '{8'h20, 32'h07d00000}};

  connector_thermal_supervisor #(.DEADLINE(DL)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat), .wb_ack_o(ack), .temp_i(temp),
    .cool_fail_i(cool_fail), .session_req_i(req), .session_end_i(fin), .session_on_o(on),
    .shutdown_req_o(shut), .current_limit_o(lim), .limit_update_o(upd),
    .lockout_o(lock), .irq_o(irq));
  thsup_partner far (.mclk_i(mclk_i), .pos_set_i(pos_t), .neg_set_i(neg_t),
    .pos_open_i(pos_open), .neg_open_i(neg_open), .cool_bad_i(cool_bad),
    .temp_o(temp), .cool_fail_o(cool_fail));

  // --------------------------------------------------------------------------
  // Compare, bus and wait helpers
  // --------------------------------------------------------------------------
  task chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request held until ack is seen high; released only after that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= d;
    k = 0;
    do begin @(posedge mclk_i); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) begin failures++; wrap_up(); end
    // Data taken and request dropped at the very edge where ack is seen high
    rd = wb_dat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    // Let the register update settle before the caller looks at outputs
    #1;
  endtask
  function automatic logic seen(input int w);
    case (w)
      0: seen = shut;
      1: seen = upd;
      2: seen = on | lock;
      default: seen = !shut && !on;
    endcase
  endfunction
  // Bounded wait; a run-out counts as a mismatch and closes the run
  task await(input int w, output int k);
    k = 0;
    do begin @(posedge mclk_i); #1; k++; end while (seen(w) !== 1'b1 && k < 200);
    if (seen(w) !== 1'b1) begin failures++; wrap_up(); end
  endtask
  task start_sess;
    @(posedge mclk_i) req <= 1'b1;
    await(2, n);
    @(posedge mclk_i) req <= 1'b0;
  endtask
  task end_sess;
    @(posedge mclk_i) fin <= 1'b1;
    await(3, n);
    @(posedge mclk_i) fin <= 1'b0;
  endtask
  // One extra cycle in each deadline check is the sensor model's register
  task ovt_run(input logic neg_side);
    start_sess();
    @(posedge mclk_i) if (neg_side) neg_t <= 12'h385; else pos_t <= 12'h385;
    await(0, n);
    chk_bit("overtemp deadline", 1'b1, n <= DL + 1);
    @(posedge mclk_i) begin pos_t <= 12'h0fa; neg_t <= 12'h104; end
    end_sess();
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial forever #20 mclk_i = ~mclk_i;
  initial begin
    #4000000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk_bit("lockout", 1'b0, lock);
    chk_word("reset limit", 32'h0, {16'h0, lim});
    foreach (rows[i]) begin
      bus(1'b0, rows[i].adr, 32'h0);
      chk_word("register", rows[i].exp, rd);
    end
    bus(1'b0, 8'h40, 32'h0);
    chk_word("unmapped", 32'h0, rd);
    bus(1'b1, 8'h0c, 32'h1f);
    bus(1'b1, 8'h18, 32'h3ff); // Long filter so only the deadline fires
    // Exactly 90.0 degC is not over the limit
    start_sess();
    chk_bit("session on", 1'b1, on);
    chk_word("start limit", 32'h1f4, {16'h0, lim});
    @(posedge mclk_i) pos_t <= 12'h384;
    repeat (3 * DL) @(posedge mclk_i);
    #1 chk_bit("at limit", 1'b0, shut);
    @(posedge mclk_i) pos_t <= 12'h0fa;
    end_sess();
    ovt_run(1'b0);
    ovt_run(1'b1);
    bus(1'b0, 8'h04, 32'h0);
    chk_word("run count", 32'h2, {30'h0, rd[3:2]});
    start_sess();
    end_sess();
    bus(1'b0, 8'h04, 32'h0);
    chk_word("clean end", 32'h0, {30'h0, rd[3:2]});
    for (int i = 0; i < 3; i++) ovt_run(1'b1);
    chk_bit("ovt lockout", 1'b1, lock);
    chk_bit("irq raised", 1'b1, irq);
    bus(1'b0, 8'h08, 32'h0);
    chk_word("irq status", 32'h11, rd);
    @(posedge mclk_i) req <= 1'b1;
    repeat (8) @(posedge mclk_i);
    #1 chk_bit("refused", 1'b0, on);
    @(posedge mclk_i) req <= 1'b0;
    bus(1'b1, 8'h08, 32'h1f);
    chk_bit("irq cleared", 1'b0, irq);
    bus(1'b1, 8'h00, 32'h1);
    chk_bit("serviced", 1'b0, lock);
    // Channel drops out in mid-session
    start_sess();
    @(posedge mclk_i) pos_open <= 1'b1;
    await(0, n);
    chk_bit("sensor deadline", 1'b1, n <= DL + 1);
    @(posedge mclk_i) pos_open <= 1'b0;
    end_sess();
    bus(1'b0, 8'h08, 32'h0);
    chk_word("sensor irq", 32'h02, rd);
    bus(1'b1, 8'h08, 32'h1f);
    // Plausibility failure before the session
    bus(1'b1, 8'h14, 32'h64);
    @(posedge mclk_i) neg_open <= 1'b1;
    @(posedge mclk_i) req <= 1'b1;
    await(2, n);
    chk_bit("check lock", 1'b1, lock);
    chk_word("capped", 32'h64, {16'h0, lim});
    @(posedge mclk_i) neg_open <= 1'b0;
    repeat (8) @(posedge mclk_i);
    #1 chk_bit("no start", 1'b0, on);
    @(posedge mclk_i) req <= 1'b0;
    bus(1'b1, 8'h00, 32'h1);
    chk_bit("unlocked", 1'b0, lock);
    // Cooling loss with and without a no-cooling current
    start_sess();
    @(posedge mclk_i) cool_bad <= 1'b1;
    await(1, n);
    chk_word("cut limit", 32'h64, {16'h0, lim});
    chk_bit("still on", 1'b1, on);
    @(posedge mclk_i) cool_bad <= 1'b0;
    end_sess();
    bus(1'b1, 8'h14, 32'h0);
    start_sess();
    @(posedge mclk_i) cool_bad <= 1'b1;
    await(0, n);
    chk_bit("cool stop", 1'b1, n <= 3);
    @(posedge mclk_i) cool_bad <= 1'b0;
    end_sess();
    bus(1'b1, 8'h0c, 32'h0);
    chk_bit("masked", 1'b0, irq);
    bus(1'b1, 8'h0c, 32'h04);
    chk_bit("unmasked", 1'b1, irq);
    wrap_up();
  end
endmodule // connector_thermal_supervisor_bench
